//--- hw/mpi_map.svh
`ifndef MPI_MAP_SVH
`define MPI_MAP_SVH

// Clock rates
`define MPI_MCLK_HZ 100000000
`define MPI_MCLK_NS (1000000000 / `MPI_MCLK_HZ)
`define MPI_HZ_100 25000000
`define MPI_HZ_10 2500000
`define MPI_HALF_100 (`MPI_MCLK_HZ / `MPI_HZ_100 / 2)
`define MPI_HALF_10 (`MPI_MCLK_HZ / `MPI_HZ_10 / 2)

// Strap and control word layout
`define MPI_STRAP_MII 3'h0
`define MPI_CTRL_SPEED_BIT 13
`define MPI_CTRL_ANEN_BIT 12
`define MPI_CTRL_DUPLEX_BIT 8

// Line symbol codes; MPI_SYM_END is /T/R at 100M and the end marker at 10M
`define MPI_SYM_IDLE 3'h0
`define MPI_SYM_DATA 3'h1
`define MPI_SYM_JK 3'h2
`define MPI_SYM_END 3'h3
`define MPI_SYM_ERR 3'h4

// Nibble values
`define MPI_NIB_ZERO 4'h0
`define MPI_NIB_PRE 4'h5
`define MPI_NIB_SFD 4'hd

// Jabber timing
`define MPI_JABBER_MS 20
`define MPI_UNJAB_MS 250
`define MPI_MS_CYCLES (`MPI_MCLK_HZ / 1000)

// Signal-quality test pulse timing
`define MPI_SQE_DELAY_NS 1000
`define MPI_SQE_LEN_NS 1000
`define MPI_SQE_DELAY_CYC ((`MPI_SQE_DELAY_NS + `MPI_MCLK_NS - 1) / `MPI_MCLK_NS)
`define MPI_SQE_LEN_CYC ((`MPI_SQE_LEN_NS + `MPI_MCLK_NS - 1) / `MPI_MCLK_NS)

`endif

//--- hw/mpi_pkg.sv
package mpi_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_PRE,
        RX_FRAME
    } mpi_rx_state_t;

    // One receive nibble on its way to the MAC
    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] nib;
    } mpi_rx_nib_t;

endpackage

//--- hw/mpi_mii_phy.sv
// Contract
// - Separate 4-bit transmit and receive nibble paths.
// - Strap 000 plus reference selects nibble mode.
// - Continuous transmit clock, 2.5 or 25 MHz.
// - TXD nibbles accepted whenever TXEN high.
// - TXD ignored while TXEN low.
// - 10M receive clock recovered only during carrier.
// - 100M receive clock recovered unless link down.
// - Receive clock 2.5 or 25 MHz.
// - 10M data valid starts at the last preamble nibble before SFD.
// - 100M data valid covers whole frame.
// - One nibble per receive clock while valid.
// - Coding error raises RXER one period minimum.
// - 10M carrier: preamble on, end marker off.
// - 100M carrier: J/K on, T/R off.
// - 100M carrier drops on IDLE without T/R.
// - Half duplex collision when both active.
// - 10M jabber: 20ms on, 250ms off.
// - 10M collision test pulse after each frame.
// - Forced speed bit 13, duplex bit 8.
`timescale 1ns/10ps
`default_nettype none
`include "mpi_map.svh"

module mpi_mii_phy
    import mpi_pkg::*;
#(
    parameter int JABBER_CYCLES = `MPI_JABBER_MS * `MPI_MS_CYCLES,
    parameter int UNJAB_CYCLES = `MPI_UNJAB_MS * `MPI_MS_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [2:0] CONFIG,
    input wire logic REF_OK,
    input wire logic [15:0] CTRL_WORD,
    input wire logic AN_SPEED_100,
    input wire logic AN_FULL_DUPLEX,
    output logic MII_ACTIVE,
    output logic TXC,
    input wire logic TXEN,
    input wire logic [3:0] TXD,
    output logic RXC,
    output logic RXDV,
    output logic [3:0] RXD,
    output logic RXER,
    output logic CRS,
    output logic COL,
    output logic LINE_TX_VALID,
    output logic [3:0] LINE_TX_NIBBLE,
    input wire logic LINE_LINK_UP,
    input wire logic LINE_RX_CARRIER,
    input wire logic LINE_RX_STROBE,
    input wire logic [2:0] LINE_RX_CODE,
    input wire logic [3:0] LINE_RX_NIBBLE
);

    logic strap_taken;
    logic [2:0] strap;
    logic speed100;
    logic full_duplex;
    logic [5:0] half;
    logic [5:0] tx_cnt;
    logic tx_tick;
    logic txen_s;
    logic [5:0] rx_cnt;
    logic use_rec;
    logic rx_tick;
    logic [2:0] sym_code;
    logic [3:0] sym_nib;
    mpi_rx_state_t rx_state;
    mpi_rx_state_t next_rx_state;
    mpi_rx_nib_t stage;
    mpi_rx_nib_t next_stage;
    logic next_crs;
    logic sfd_hit;
    logic jab;
    logic [24:0] jab_cnt;
    logic [7:0] sqe_cnt;
    logic sqe_on;
    logic frame_end;

    function automatic logic [5:0] half_of(input logic fast);
        half_of = fast ? 6'(`MPI_HALF_100) : 6'(`MPI_HALF_10);
    endfunction

    // Strap is caught on the first edge after reset release
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_taken <= 1'b0;
            strap <= 3'h0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            strap <= CONFIG;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            MII_ACTIVE <= 1'b0;
        end else begin
            MII_ACTIVE <= strap_taken && (strap == `MPI_STRAP_MII) && REF_OK;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            speed100 <= 1'b0;
            full_duplex <= 1'b0;
        end else if (CTRL_WORD[`MPI_CTRL_ANEN_BIT]) begin
            speed100 <= AN_SPEED_100;
            full_duplex <= AN_FULL_DUPLEX;
        end else begin
            speed100 <= CTRL_WORD[`MPI_CTRL_SPEED_BIT];
            full_duplex <= CTRL_WORD[`MPI_CTRL_DUPLEX_BIT];
        end
    end

    assign half = half_of(speed100);

    // Transmit clock divider; tick marks the MCLK edge on which TXC rises
    assign tx_tick = MII_ACTIVE && (tx_cnt == half - 6'h01) && !TXC;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_cnt <= 6'h00;
            TXC <= 1'b0;
        end else if (!MII_ACTIVE) begin
            tx_cnt <= 6'h00;
            TXC <= 1'b0;
        end else if (tx_cnt >= half - 6'h01) begin
            tx_cnt <= 6'h00;
            TXC <= ~TXC;
        end else begin
            tx_cnt <= tx_cnt + 6'h01;
        end
    end

    // Transmit nibble path towards the line
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            txen_s <= 1'b0;
            LINE_TX_VALID <= 1'b0;
            LINE_TX_NIBBLE <= `MPI_NIB_ZERO;
        end else if (!MII_ACTIVE) begin
            txen_s <= 1'b0;
            LINE_TX_VALID <= 1'b0;
            LINE_TX_NIBBLE <= `MPI_NIB_ZERO;
        end else if (tx_tick) begin
            txen_s <= TXEN;
            LINE_TX_VALID <= TXEN && !jab;
            LINE_TX_NIBBLE <= TXEN ? TXD : `MPI_NIB_ZERO;
        end
    end

    // MAC ends a frame by dropping TXEN before the next rising edge
    assign frame_end = tx_tick && txen_s && !TXEN;

    // Jabber guard, counted in MCLK cycles at 10M only
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            jab <= 1'b0;
            jab_cnt <= 25'h0;
        end else if (speed100 || !MII_ACTIVE) begin
            jab <= 1'b0;
            jab_cnt <= 25'h0;
        end else if (!jab) begin
            if (!txen_s) begin
                jab_cnt <= 25'h0;
            end else if (jab_cnt >= 25'(JABBER_CYCLES)) begin
                jab <= 1'b1;
                jab_cnt <= 25'h0;
            end else begin
                jab_cnt <= jab_cnt + 25'h1;
            end
        end else begin
            if (txen_s) begin
                jab_cnt <= 25'h0;
            end else if (jab_cnt >= 25'(UNJAB_CYCLES)) begin
                jab <= 1'b0;
                jab_cnt <= 25'h0;
            end else begin
                jab_cnt <= jab_cnt + 25'h1;
            end
        end
    end

    // Test pulse: delay then width, counted down from frame end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sqe_cnt <= 8'h00;
        end else if (speed100 || !MII_ACTIVE) begin
            sqe_cnt <= 8'h00;
        end else if (frame_end) begin
            sqe_cnt <= 8'(`MPI_SQE_DELAY_CYC + `MPI_SQE_LEN_CYC);
        end else if (sqe_cnt != 8'h00) begin
            sqe_cnt <= sqe_cnt - 8'h01;
        end
    end

    assign sqe_on = (sqe_cnt != 8'h00) && (sqe_cnt <= 8'(`MPI_SQE_LEN_CYC));

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            COL <= 1'b0;
        end else if (!MII_ACTIVE) begin
            COL <= 1'b0;
        end else begin
            COL <= jab || sqe_on || (!full_duplex && txen_s && (LINE_RX_CARRIER || CRS));
        end
    end

    // Receive clock source selection
    assign use_rec = LINE_LINK_UP && (speed100 || LINE_RX_CARRIER);
    assign rx_tick = MII_ACTIVE &&
        (use_rec ? LINE_RX_STROBE : ((rx_cnt >= half - 6'h01) && RXC));
    assign sym_code = use_rec ? LINE_RX_CODE : `MPI_SYM_IDLE;
    assign sym_nib = use_rec ? LINE_RX_NIBBLE : `MPI_NIB_ZERO;

    // A recovered strobe re-phases the divider; otherwise it runs free
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_cnt <= 6'h00;
            RXC <= 1'b0;
        end else if (!MII_ACTIVE) begin
            rx_cnt <= 6'h00;
            RXC <= 1'b0;
        end else if (rx_tick) begin
            rx_cnt <= 6'h00;
            RXC <= 1'b0;
        end else if (rx_cnt >= half - 6'h01) begin
            rx_cnt <= 6'h00;
            RXC <= ~RXC;
        end else begin
            rx_cnt <= rx_cnt + 6'h01;
        end
    end

    // Receive framing; one nibble of look-ahead finds the 10M delimiter
    always_comb begin
        next_rx_state = rx_state;
        next_stage = '{dv: 1'b0, er: 1'b0, nib: `MPI_NIB_ZERO};
        next_crs = CRS;
        sfd_hit = 1'b0;
        case (rx_state)
            RX_IDLE: begin
                if (speed100) begin
                    if (sym_code == `MPI_SYM_JK) begin
                        next_rx_state = RX_FRAME;
                        next_crs = 1'b1;
                        next_stage = '{dv: 1'b1, er: 1'b0, nib: `MPI_NIB_PRE};
                    end
                end else if (LINE_RX_CARRIER && (sym_code == `MPI_SYM_DATA) &&
                             (sym_nib == `MPI_NIB_PRE)) begin
                    next_rx_state = RX_PRE;
                    next_crs = 1'b1;
                    next_stage = '{dv: 1'b0, er: 1'b0, nib: sym_nib};
                end
            end
            RX_PRE: begin
                if (speed100 || !LINE_RX_CARRIER || (sym_code != `MPI_SYM_DATA)) begin
                    next_rx_state = RX_IDLE;
                    next_crs = 1'b0;
                end else if ((sym_nib == `MPI_NIB_SFD) && (stage.nib == `MPI_NIB_PRE)) begin
                    sfd_hit = 1'b1;
                    next_rx_state = RX_FRAME;
                    next_stage = '{dv: 1'b1, er: 1'b0, nib: sym_nib};
                end else begin
                    next_stage = '{dv: 1'b0, er: 1'b0, nib: sym_nib};
                end
            end
            RX_FRAME: begin
                if (speed100 &&
                    ((sym_code == `MPI_SYM_END) || (sym_code == `MPI_SYM_IDLE))) begin
                    next_rx_state = RX_IDLE;
                    next_crs = 1'b0;
                end else if (!speed100 &&
                             (!LINE_RX_CARRIER || (sym_code == `MPI_SYM_END))) begin
                    next_rx_state = RX_IDLE;
                    next_crs = 1'b0;
                end else begin
                    next_stage = '{dv: 1'b1, er: (sym_code == `MPI_SYM_ERR), nib: sym_nib};
                end
            end
            default: begin
                next_rx_state = RX_IDLE;
                next_crs = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_state <= RX_IDLE;
            stage <= '{dv: 1'b0, er: 1'b0, nib: `MPI_NIB_ZERO};
            CRS <= 1'b0;
        end else if (!MII_ACTIVE) begin
            rx_state <= RX_IDLE;
            stage <= '{dv: 1'b0, er: 1'b0, nib: `MPI_NIB_ZERO};
            CRS <= 1'b0;
        end else if (rx_tick) begin
            rx_state <= next_rx_state;
            stage <= next_stage;
            CRS <= next_crs;
        end
    end

    // Receive outputs change only as RXC falls
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RXDV <= 1'b0;
            RXD <= `MPI_NIB_ZERO;
            RXER <= 1'b0;
        end else if (!MII_ACTIVE) begin
            RXDV <= 1'b0;
            RXD <= `MPI_NIB_ZERO;
            RXER <= 1'b0;
        end else if (rx_tick) begin
            RXDV <= stage.dv || sfd_hit;
            RXD <= (stage.dv || sfd_hit) ? stage.nib : `MPI_NIB_ZERO;
            RXER <= stage.dv && stage.er;
        end
    end

endmodule // mpi_mii_phy
`default_nettype wire

//--- tb/mpi_mii_phy_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mpi_mii_phy_asserts (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [15:0] CTRL_WORD,
    input wire logic AN_SPEED_100,
    input wire logic MII_ACTIVE,
    input wire logic TXC,
    input wire logic TXEN,
    input wire logic [3:0] TXD,
    input wire logic RXC,
    input wire logic RXDV,
    input wire logic [3:0] RXD,
    input wire logic RXER,
    input wire logic CRS,
    input wire logic COL,
    input wire logic LINE_TX_VALID,
    input wire logic [3:0] LINE_TX_NIBBLE,
    input wire logic LINE_LINK_UP,
    input wire logic LINE_RX_STROBE,
    input wire logic [2:0] LINE_RX_CODE
);
    logic spd;
    logic stb;
    assign spd = CTRL_WORD[12] ? AN_SPEED_100 : CTRL_WORD[13];
    // Recovered 100M strobe that the receive side must act on
    assign stb = LINE_RX_STROBE && LINE_LINK_UP && spd && MII_ACTIVE;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_tx_idle;
        $rose(TXC) && !$past(TXEN) |-> LINE_TX_NIBBLE == 4'h0 && !LINE_TX_VALID;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("idle nibble leaked");
    property p_tx_take;
        $rose(TXC) && $past(TXEN) |-> LINE_TX_NIBBLE == $past(TXD) && (LINE_TX_VALID || COL);
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("nibble not taken");
    property p_txc_100;
        $rose(TXC) && spd |=> TXC ##1 !TXC [*2] ##1 TXC;
    endproperty
    a_txc_100: assert property (p_txc_100) else $error("transmit clock shape");
    property p_rx_sync;
        $changed(RXDV) || $changed(RXD) || $changed(RXER) |-> !RXC;
    endproperty
    a_rx_sync: assert property (p_rx_sync) else $error("receive output off clock");
    property p_rx_clk;
        stb |=> !RXC [*2] ##1 RXC;
    endproperty
    a_rx_clk: assert property (p_rx_clk) else $error("receive clock not recovered");
    property p_crs_jk;
        stb && LINE_RX_CODE == 3'h2 |=> CRS;
    endproperty
    a_crs_jk: assert property (p_crs_jk) else $error("carrier not raised");
    property p_crs_end;
        stb && CRS && (LINE_RX_CODE == 3'h3 || LINE_RX_CODE == 3'h0) |=> !CRS;
    endproperty
    a_crs_end: assert property (p_crs_end) else $error("carrier not dropped");
    property p_dv_start;
        $rose(RXDV) |-> CRS && RXD == 4'h5;
    endproperty
    a_dv_start: assert property (p_dv_start) else $error("valid start wrong");
    property p_rxer;
        stb && CRS && LINE_RX_CODE == 3'h4 |-> ##[1:8] RXER && RXDV;
    endproperty
    a_rxer: assert property (p_rxer) else $error("error not flagged");
    property p_col_full;
        !CTRL_WORD[12] && CTRL_WORD[8] && spd |-> !COL;
    endproperty
    a_col_full: assert property (p_col_full) else $error("collision in full duplex");
endmodule // mpi_mii_phy_asserts
bind mpi_mii_phy mpi_mii_phy_asserts u_chk (
    .MCLK(MCLK), .RST_N(RST_N), .CTRL_WORD(CTRL_WORD), .AN_SPEED_100(AN_SPEED_100),
    .MII_ACTIVE(MII_ACTIVE), .TXC(TXC), .TXEN(TXEN), .TXD(TXD), .RXC(RXC), .RXDV(RXDV),
    .RXD(RXD), .RXER(RXER), .CRS(CRS), .COL(COL), .LINE_TX_VALID(LINE_TX_VALID),
    .LINE_TX_NIBBLE(LINE_TX_NIBBLE), .LINE_LINK_UP(LINE_LINK_UP),
    .LINE_RX_STROBE(LINE_RX_STROBE), .LINE_RX_CODE(LINE_RX_CODE)
);
`default_nettype wire

//--- tb/mpi_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpi_mac_model (
    input wire logic MCLK,
    input wire logic TXC,
    input wire logic RXC,
    input wire logic RXDV,
    input wire logic [3:0] RXD,
    input wire logic RXER,
    output logic TXEN,
    output logic [3:0] TXD
);
    logic [3:0] rxq[$];
    logic rx_err = 1'b0;
    logic dirty = 1'b0;
    initial begin
        TXEN = 1'b0;
        TXD = 4'h0;
    end
    always @(posedge RXC) begin
        if (RXDV) begin
            rxq.push_back(RXD);
            if (RXER) rx_err = 1'b1;
        end
    end
    // Dirty mode puts junk on the data lines while idle
    // Lines move half an MCLK after the TXC rise, clear of the sampling edge
    task automatic send(input logic [3:0] nib[$]);
        foreach (nib[i]) begin
            @(posedge TXC);
            @(negedge MCLK);
            TXEN = 1'b1;
            TXD = nib[i];
        end
        @(posedge TXC);
        @(negedge MCLK);
        TXEN = 1'b0;
        TXD = dirty ? 4'hf : 4'h0;
    endtask
endmodule // mpi_mac_model
`default_nettype wire

//--- tb/mpi_mii_phy_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module mpi_mii_phy_tb_top;
    logic MCLK, RST_N, REF_OK, AN_SPEED_100, TXEN, stb, carr, txc_q, col_seen, link;
    logic MII_ACTIVE, TXC, RXC, RXDV, RXER, CRS, COL, LINE_TX_VALID;
    logic [2:0] CONFIG, code;
    logic [15:0] CTRL_WORD;
    logic [3:0] TXD, RXD, LINE_TX_NIBBLE, rnib;
    logic [3:0] txq[$];
    int err_total = 0, cmp_count = 0, cnt = 0, per = 0;
    mpi_mii_phy #(.JABBER_CYCLES(50), .UNJAB_CYCLES(80)) DUT (
        .MCLK(MCLK), .RST_N(RST_N), .CONFIG(CONFIG), .REF_OK(REF_OK), .CTRL_WORD(CTRL_WORD),
        .AN_SPEED_100(AN_SPEED_100), .AN_FULL_DUPLEX(1'b0), .MII_ACTIVE(MII_ACTIVE),
        .TXC(TXC), .TXEN(TXEN), .TXD(TXD), .RXC(RXC), .RXDV(RXDV), .RXD(RXD), .RXER(RXER),
        .CRS(CRS), .COL(COL), .LINE_TX_VALID(LINE_TX_VALID), .LINE_TX_NIBBLE(LINE_TX_NIBBLE),
        .LINE_LINK_UP(link), .LINE_RX_CARRIER(carr), .LINE_RX_STROBE(stb),
        .LINE_RX_CODE(code), .LINE_RX_NIBBLE(rnib));
    mpi_mac_model mac (.MCLK(MCLK), .TXC(TXC), .RXC(RXC), .RXDV(RXDV), .RXD(RXD), .RXER(RXER),
        .TXEN(TXEN), .TXD(TXD));
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    // Transmit clock period in MCLK cycles and nibbles handed to the line
    always @(posedge MCLK) begin
        txc_q <= TXC;
        cnt <= (TXC && !txc_q) ? 1 : cnt + 1;
        if (TXC && !txc_q) per <= cnt;
        if (TXC && !txc_q && LINE_TX_VALID) txq.push_back(LINE_TX_NIBBLE);
        if (COL !== 1'b0) col_seen = COL;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic rst(input logic [15:0] w);
        @(negedge MCLK);
        RST_N = 1'b0;
        CTRL_WORD = w;
        wt(2);
        RST_N = 1'b1;
        wt(4);
        col_seen = 1'b0;
        txq.delete();
        mac.rxq.delete();
        mac.rx_err = 1'b0;
    endtask
    task automatic sym(input logic [2:0] c, input logic [3:0] n, input int g);
        stb = 1'b1;
        code = c;
        rnib = n;
        wt(1);
        stb = 1'b0;
        code = ~c;
        rnib = ~n;
        wt(g - 1);
    endtask
    task automatic rxf(input logic [2:0] mid, input logic [2:0] endc);
        logic [3:0] f[$] = '{4'h5, 4'h5, 4'hd, 4'h1, 4'h2};
        carr = 1'b1;
        sym(3'h2, 4'h0, 4);
        foreach (f[i]) sym((i == 2) ? mid : 3'h1, f[i], 4);
        sym(endc, 4'h0, 4);
        sym(3'h0, 4'h0, 4);
        carr = 1'b0;
        chk(CRS, 0);
        // The start-of-stream pair reaches the MAC as one leading preamble nibble
        chk(mac.rxq.size(), 6);
        chk(mac.rxq[0], 4'h5);
        foreach (f[i]) chk(mac.rxq[i + 1], f[i]);
        chk(mac.rx_err, mid == 3'h4);
    endtask
    task automatic t_clk;
        logic [15:0] w[3] = '{16'h2000, 16'h0000, 16'h1000};
        int p[3] = '{4, 40, 4};
        for (int i = 0; i < 3; i++) begin
            rst(w[i]);
            wt(100);
            chk(MII_ACTIVE, 1);
            chk(per, p[i]);
        end
        CONFIG = 3'h1;
        rst(16'h2000);
        chk(MII_ACTIVE, 0);
        CONFIG = 3'h0;
        REF_OK = 1'b0;
        rst(16'h2000);
        chk(MII_ACTIVE, 0);
        REF_OK = 1'b1;
    endtask
    task automatic t_tx;
        logic [3:0] f[$] = '{4'h5, 4'h5, 4'hd, 4'ha};
        rst(16'h2100);
        mac.dirty = 1'b1;
        mac.send(f);
        wt(20);
        mac.dirty = 1'b0;
        chk(txq.size(), 4);
        foreach (f[i]) chk(txq[i], f[i]);
        chk(LINE_TX_NIBBLE, 0);
    endtask
    task automatic t_both(input logic [15:0] w, input logic [2:0] mid, input logic [2:0] e);
        rst(w);
        fork
            mac.send('{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'hd, 4'h3});
            rxf(mid, e);
        join
        chk(col_seen, !w[8]);
        // With the link down, recovered symbols must not reach the framer
        link = 1'b0;
        sym(3'h2, 4'h0, 4);
        chk(CRS, 0);
        link = 1'b1;
    endtask
    task automatic t_rx10;
        rst(16'h0100);
        carr = 1'b1;
        sym(3'h1, 4'h5, 40);
        chk(CRS, 1);
        sym(3'h1, 4'h5, 40);
        sym(3'h1, 4'hd, 40);
        sym(3'h1, 4'h7, 40);
        sym(3'h3, 4'h0, 40);
        chk(CRS, 0);
        sym(3'h0, 4'h0, 40);
        carr = 1'b0;
        chk(mac.rxq.size(), 3);
        chk({mac.rxq[0], mac.rxq[1], mac.rxq[2]}, 12'h5d7);
    endtask
    task automatic t_col10;
        rst(16'h0100);
        mac.send('{4'h5});
        wt(300);
        chk(col_seen, 1);
        mac.send('{4'h5, 4'h5, 4'h5, 4'h5});
        wt(2);
        chk({COL, LINE_TX_VALID}, 2'b10);
        wt(300);
        chk(COL, 0);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        RST_N = 1'b0;
        CONFIG = 3'h0;
        REF_OK = 1'b1;
        AN_SPEED_100 = 1'b1;
        CTRL_WORD = 16'h2000;
        {stb, carr, code, rnib, col_seen} = '0;
        link = 1'b1;
        wt(10);
        RST_N = 1'b1;
        t_clk();
        t_tx();
        t_both(16'h2000, 3'h1, 3'h3);
        t_both(16'h2100, 3'h4, 3'h0);
        t_rx10();
        t_col10();
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 100000; i++) @(posedge MCLK);
        err_total++;
        end_of_test();
    end
endmodule // mpi_mii_phy_tb_top
`default_nettype wire
